/* File: cfd_data_port.sv */
// CPU data window that pops and pushes bytes of the attached FIFO
//
// Operation
// - Read lanes pop the read-attached FIFO
// - Write lanes push into write-attached FIFO
// - 8-bit mode: either read lane gives next byte
// - 8-bit mode: either write lane appends one byte
// - 16-bit odd boundary: read fills one lane only
// - 16-bit odd boundary: write stores one lane only
// - Addresses 2A to 2F do nothing
// - 13-bit count, valid flag, high byte first
`timescale 1ns/1ps
`default_nettype none
module cfd_data_port #(
  parameter int NUM_FIFO = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cpu_bus16,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  output logic cpu_rdata_valid,
  output logic cpu_wr_ready,
  input wire logic [NUM_FIFO-1:0] cpu_read_attach,
  input wire logic [NUM_FIFO-1:0] cpu_write_attach,
  input wire logic [NUM_FIFO*16-1:0] rd_src_data,
  input wire logic [NUM_FIFO*13-1:0] readable_byte_count,
  input wire logic [NUM_FIFO-1:0] readable_count_valid,
  output logic [NUM_FIFO-1:0] rd_pop,
  output logic rd_pop_two,
  input wire logic [NUM_FIFO*13-1:0] free_space_count,
  input wire logic [NUM_FIFO-1:0] wr_dst_ready,
  output logic [NUM_FIFO-1:0] wr_push,
  output logic [15:0] wr_push_data,
  output logic wr_push_two
);
  // ----------------------------------------------------------------
  // Attached FIFO selection
  // ----------------------------------------------------------------
  logic [15:0] rd_data_m [NUM_FIFO];
  logic [12:0] rd_cnt_m [NUM_FIFO];
  logic [12:0] free_m [NUM_FIFO];
  logic [NUM_FIFO-1:0] rd_cnt_ok_m;
  logic [15:0] sel_rd_data;
  logic [12:0] sel_rd_cnt;
  logic [12:0] sel_free;
  logic sel_rd_valid;
  logic rd_att;
  logic wr_att;

  // Each FIFO's view is masked by its attach bit so a plain OR selects it
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FIFO; gi++) begin : g_fifo
      assign rd_data_m[gi] = cpu_read_attach[gi] ? rd_src_data[gi*16 +: 16] : 16'h0000;
      assign rd_cnt_m[gi] = cpu_read_attach[gi] ? readable_byte_count[gi*13 +: 13] : 13'h0000;
      assign rd_cnt_ok_m[gi] = cpu_read_attach[gi] & readable_count_valid[gi];
      assign free_m[gi] = cpu_write_attach[gi] ? free_space_count[gi*13 +: 13] : 13'h0000;
    end
  endgenerate

  // OR-reduce the masked views; attach bits are one-hot by contract
  always_comb begin
    sel_rd_data = 16'h0000;
    sel_rd_cnt = 13'h0000;
    sel_free = 13'h0000;
    for (int i = 0; i < NUM_FIFO; i++) begin
      sel_rd_data = sel_rd_data | rd_data_m[i];
      sel_rd_cnt = sel_rd_cnt | rd_cnt_m[i];
      sel_free = sel_free | free_m[i];
    end
    sel_rd_valid = |rd_cnt_ok_m;
    rd_att = |cpu_read_attach;
    wr_att = |cpu_write_attach;
  end

  // ----------------------------------------------------------------
  // Read path and count registers
  // ----------------------------------------------------------------
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic [NUM_FIFO-1:0] pop_ff, nxt_pop;
  logic pop_two_ff, nxt_pop_two;
  logic [7:0] lo_snap_ff, nxt_lo_snap;
  logic rd_hit;
  logic rd_take;
  logic rd_two;
  logic [12:0] rd_avail;

  // A data read latches the bytes and pops them one cycle later, so the
  // host must leave a gap cycle between data reads for the FIFO to advance
  always_comb begin
    rd_hit = cpu_rd && (cpu_addr == cfd_pkg::FIFO_READ_LANE0 ||
                        cpu_addr == cfd_pkg::FIFO_READ_LANE1);
    rd_avail = sel_rd_valid ? sel_rd_cnt : cfd_pkg::NO_BYTES;
    rd_take = rd_hit && rd_att && (rd_avail != cfd_pkg::NO_BYTES);
    rd_two = cpu_bus16 && (rd_avail >= cfd_pkg::TWO_BYTES);
    nxt_rvalid = cpu_rd;
    nxt_pop = rd_take ? cpu_read_attach : '0;
    nxt_pop_two = rd_take && rd_two;
    nxt_lo_snap = lo_snap_ff;
    nxt_rdata = {cfd_pkg::UNDEF_BYTE, cfd_pkg::UNDEF_BYTE};
    if (rd_take) begin
      // Either lane address gives the next byte; odd boundary fills lane 0 only
      nxt_rdata = rd_two ? sel_rd_data : {cfd_pkg::UNDEF_BYTE, sel_rd_data[7:0]};
    end else if (cpu_rd) begin
      case (cpu_addr)
        cfd_pkg::READABLE_COUNT_HI: begin
          // High read snapshots the low byte so the pair stays coherent
          nxt_rdata = {cfd_pkg::UNDEF_BYTE, sel_rd_valid, 2'h0, rd_avail[12:8]};
          nxt_lo_snap = rd_avail[7:0];
        end
        cfd_pkg::READABLE_COUNT_LO: nxt_rdata = {cfd_pkg::UNDEF_BYTE, lo_snap_ff};
        cfd_pkg::FREE_SPACE_HI: begin
          nxt_rdata = {cfd_pkg::UNDEF_BYTE, 3'h0, sel_free[12:8]};
          nxt_lo_snap = sel_free[7:0];
        end
        cfd_pkg::FREE_SPACE_LO: nxt_rdata = {cfd_pkg::UNDEF_BYTE, lo_snap_ff};
        default: nxt_rdata = {cfd_pkg::UNDEF_BYTE, cfd_pkg::UNDEF_BYTE};
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_ff <= cfd_pkg::RDATA_RST;
      rvalid_ff <= 1'b0;
      pop_ff <= '0;
      pop_two_ff <= 1'b0;
      lo_snap_ff <= cfd_pkg::LO_SNAP_RST;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      pop_ff <= nxt_pop;
      pop_two_ff <= nxt_pop_two;
      lo_snap_ff <= nxt_lo_snap;
    end
  end

  // ----------------------------------------------------------------
  // Write path: two-entry buffer, head entry drives the push outputs
  // ----------------------------------------------------------------
  logic [NUM_FIFO-1:0] head_sel_ff, nxt_head_sel, tail_sel_ff, nxt_tail_sel;
  logic [15:0] head_data_ff, nxt_head_data, tail_data_ff, nxt_tail_data;
  logic head_two_ff, nxt_head_two, tail_two_ff, nxt_tail_two;
  logic wr_ready_ff, nxt_wr_ready;
  logic wr_hit;
  logic wr_acc;
  logic wr_two;
  logic head_keep;

  // Writes with nothing attached, no free space or a full buffer are dropped;
  // the host sees the drop through cpu_wr_ready and the free-space count
  always_comb begin
    wr_hit = cpu_wr && (cpu_addr == cfd_pkg::FIFO_WRITE_LANE0 ||
                        cpu_addr == cfd_pkg::FIFO_WRITE_LANE1);
    wr_acc = wr_hit && wr_att && wr_ready_ff && (sel_free != cfd_pkg::NO_BYTES);
    wr_two = cpu_bus16 && (sel_free >= cfd_pkg::TWO_BYTES);
    head_keep = (|head_sel_ff) && !(|(head_sel_ff & wr_dst_ready));
    nxt_head_sel = head_sel_ff;
    nxt_head_data = head_data_ff;
    nxt_head_two = head_two_ff;
    nxt_tail_sel = tail_sel_ff;
    nxt_tail_data = tail_data_ff;
    nxt_tail_two = tail_two_ff;
    if (!head_keep) begin
      if (|tail_sel_ff) begin
        nxt_head_sel = tail_sel_ff;
        nxt_head_data = tail_data_ff;
        nxt_head_two = tail_two_ff;
        nxt_tail_sel = wr_acc ? cpu_write_attach : '0;
        nxt_tail_data = cpu_wdata;
        nxt_tail_two = wr_two;
      end else begin
        nxt_head_sel = wr_acc ? cpu_write_attach : '0;
        nxt_head_data = cpu_wdata;
        nxt_head_two = wr_two;
      end
    end else if (!(|tail_sel_ff) && wr_acc) begin
      nxt_tail_sel = cpu_write_attach;
      nxt_tail_data = cpu_wdata;
      nxt_tail_two = wr_two;
    end
    nxt_wr_ready = !((|nxt_head_sel) && (|nxt_tail_sel));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      head_sel_ff <= '0;
      head_data_ff <= 16'h0000;
      head_two_ff <= 1'b0;
      tail_sel_ff <= '0;
      tail_data_ff <= 16'h0000;
      tail_two_ff <= 1'b0;
      wr_ready_ff <= 1'b0;
    end else begin
      head_sel_ff <= nxt_head_sel;
      head_data_ff <= nxt_head_data;
      head_two_ff <= nxt_head_two;
      tail_sel_ff <= nxt_tail_sel;
      tail_data_ff <= nxt_tail_data;
      tail_two_ff <= nxt_tail_two;
      wr_ready_ff <= nxt_wr_ready;
    end
  end

  // Outputs straight from flip-flops
  assign cpu_rdata = rdata_ff;
  assign cpu_rdata_valid = rvalid_ff;
  assign cpu_wr_ready = wr_ready_ff;
  assign rd_pop = pop_ff;
  assign rd_pop_two = pop_two_ff;
  assign wr_push = head_sel_ff;
  assign wr_push_data = head_data_ff;
  assign wr_push_two = head_two_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_rd_pop;
    rd_hit && rd_att && sel_rd_valid && sel_rd_cnt != 13'h0000 |=>
      rd_pop == $past(cpu_read_attach) ##1 rd_pop == '0;
  endproperty
  a_rd_pop: assert property (p_rd_pop) else $error("read did not pop attached FIFO");

  property p_wr_push;
    wr_acc && !(|head_sel_ff) |=> wr_push == $past(cpu_write_attach)
      && wr_push_data == $past(cpu_wdata);
  endproperty
  a_wr_push: assert property (p_wr_push) else $error("write not pushed to attached FIFO");

  property p_rd8;
    rd_take && !cpu_bus16 |=> !rd_pop_two && cpu_rdata == {8'h00, $past(sel_rd_data[7:0])};
  endproperty
  a_rd8: assert property (p_rd8) else $error("8-bit read did not give one byte");

  property p_wr8;
    wr_acc && !cpu_bus16 && !(|head_sel_ff) |=> (|wr_push) && !wr_push_two;
  endproperty
  a_wr8: assert property (p_wr8) else $error("8-bit write did not append one byte");

  property p_rd16_odd;
    rd_take && cpu_bus16 && rd_avail == 13'h0001 |=> !rd_pop_two && cpu_rdata[15:8] == 8'h00;
  endproperty
  a_rd16_odd: assert property (p_rd16_odd) else $error("odd read filled both lanes");

  property p_wr16_odd;
    wr_acc && cpu_bus16 && sel_free == 13'h0001 && !(|head_sel_ff) |=> !wr_push_two;
  endproperty
  a_wr16_odd: assert property (p_wr16_odd) else $error("odd write stored both lanes");

  property p_rsvd;
    cpu_rd && cpu_addr >= cfd_pkg::RSVD_FIRST && cpu_addr <= cfd_pkg::RSVD_LAST |=>
      rd_pop == '0 && cpu_rdata == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved address had an effect");

  property p_cnt_pair;
    (cpu_rd && cpu_addr == cfd_pkg::READABLE_COUNT_HI) ##1 (!cpu_rd) [*2] ##1
      (cpu_rd && cpu_addr == cfd_pkg::READABLE_COUNT_LO) |=>
      cpu_rdata[7:0] == $past(rd_avail[7:0], 4) && rd_pop == '0;
  endproperty
  a_cnt_pair: assert property (p_cnt_pair) else $error("count pair not coherent");

  // Buffer occupancy as 00, 10 or 11; a discarded write must never raise it
  logic [1:0] buf_occ;
  assign buf_occ = {|head_sel_ff, |tail_sel_ff};

  property p_no_attach;
    (rd_hit && !rd_att |=> rd_pop == '0 && cpu_rdata == 16'h0000) and
      (wr_hit && !wr_att |=> buf_occ <= $past(buf_occ));
  endproperty
  a_no_attach: assert property (p_no_attach) else $error("unattached access changed a FIFO");
endmodule
`default_nettype wire

/* File: cfd_pkg.sv */
// Package: register offsets, widths and reset values of the CPU FIFO data port
package cfd_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RSVD_FIRST = 8'h2A;
  localparam logic [7:0] RSVD_LAST = 8'h2F;
  localparam logic [7:0] FIFO_READ_LANE0 = 8'h30;
  localparam logic [7:0] FIFO_READ_LANE1 = 8'h31;
  localparam logic [7:0] FIFO_WRITE_LANE0 = 8'h32;
  localparam logic [7:0] FIFO_WRITE_LANE1 = 8'h33;
  localparam logic [7:0] READABLE_COUNT_HI = 8'h34;
  localparam logic [7:0] READABLE_COUNT_LO = 8'h35;
  localparam logic [7:0] FREE_SPACE_HI = 8'h36;
  localparam logic [7:0] FREE_SPACE_LO = 8'h37;
  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int COUNT_W = 13;
  localparam int COUNT_VALID_BIT = 7;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [7:0] UNDEF_BYTE = 8'h00;
  localparam logic [7:0] LO_SNAP_RST = 8'h00;
  localparam logic [12:0] TWO_BYTES = 13'h0002;
  localparam logic [12:0] NO_BYTES = 13'h0000;
endpackage

/* File: cfd_fifo_model.sv */
// Partner model: two byte FIFOs behind the CPU data port
`timescale 1ns/1ps
`default_nettype none
module cfd_fifo_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] rd_pop,
  input wire logic rd_pop_two,
  input wire logic [1:0] wr_push,
  input wire logic wr_push_two,
  output logic [31:0] rd_src_data,
  output logic [25:0] readable_byte_count,
  output logic [1:0] readable_count_valid,
  output logic [25:0] free_space_count,
  output logic [1:0] wr_dst_ready
);
  logic [12:0] rc_ff [2];
  logic [12:0] fc_ff [2];
  logic [7:0] rp_ff [2];
  logic [1:0] tk_ff;
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Counts move only on an accepted pop or push
  always_ff @(posedge ref_clk) begin
    tk_ff <= rst_n ? tk_ff + 2'h1 : 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (!rst_n) begin
        rc_ff[i] <= (i == 1) ? 13'h0005 : 13'h0003;
        fc_ff[i] <= (i == 1) ? 13'h0028 : 13'h0003;
        rp_ff[i] <= (i == 1) ? 8'h40 : 8'h00;
      end else begin
        if (rd_pop[i]) begin
          rc_ff[i] <= rc_ff[i] - (rd_pop_two ? 13'h0002 : 13'h0001);
          rp_ff[i] <= rp_ff[i] + (rd_pop_two ? 8'h02 : 8'h01);
        end
        if (wr_push[i] && wr_dst_ready[i]) begin
          fc_ff[i] <= fc_ff[i] - (wr_push_two ? 13'h0002 : 13'h0001);
        end
      end
    end
  end
  // Ready falls two cycles in four, so the write buffer really stalls
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rd_src_data[i*16 +: 16] = {rp_ff[i] + 8'h01, rp_ff[i]};
      readable_byte_count[i*13 +: 13] = rc_ff[i];
      free_space_count[i*13 +: 13] = fc_ff[i];
    end
    readable_count_valid = 2'h3;
    wr_dst_ready = {2{tk_ff[1]}};
  end
endmodule
`default_nettype wire

/* File: cfd_data_port_test.sv */
// Self-checking bench for the CPU FIFO data port
`timescale 1ns/1ps
`default_nettype none
module cfd_data_port_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_bus16 = 1'b0;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic [15:0] cpu_wdata = 16'h0000;
  logic [1:0] cpu_read_attach = 2'h0;
  logic [1:0] cpu_write_attach = 2'h0;
  logic [15:0] cpu_rdata, wr_push_data;
  logic cpu_rdata_valid, cpu_wr_ready, rd_pop_two, wr_push_two;
  logic [31:0] rd_src_data;
  logic [25:0] rcnt, fcnt;
  logic [1:0] rvld, rd_pop, wr_dst_ready, wr_push;
  int errors = 0;
  int num_checks = 0;
  logic [18:0] rq[$];
  logic [18:0] wq[$];
  logic [12:0] rc[2] = '{13'h0003, 13'h0005};
  logic [12:0] fc[2] = '{13'h0003, 13'h0028};
  logic [7:0] rp[2] = '{8'h00, 8'h40};
  logic saw_full = 1'b0;
  always #50 ref_clk = ~ref_clk;
  cfd_data_port #(.NUM_FIFO(2)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .cpu_bus16(cpu_bus16), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rdata_valid(cpu_rdata_valid),
    .cpu_wr_ready(cpu_wr_ready), .cpu_read_attach(cpu_read_attach),
    .cpu_write_attach(cpu_write_attach), .rd_src_data(rd_src_data),
    .readable_byte_count(rcnt), .readable_count_valid(rvld), .rd_pop(rd_pop),
    .rd_pop_two(rd_pop_two), .free_space_count(fcnt), .wr_dst_ready(wr_dst_ready),
    .wr_push(wr_push), .wr_push_data(wr_push_data), .wr_push_two(wr_push_two));
  cfd_fifo_model u_far (.ref_clk(ref_clk), .rst_n(rst_n), .rd_pop(rd_pop),
    .rd_pop_two(rd_pop_two), .wr_push(wr_push), .wr_push_two(wr_push_two),
    .rd_src_data(rd_src_data), .readable_byte_count(rcnt), .readable_count_valid(rvld),
    .free_space_count(fcnt), .wr_dst_ready(wr_dst_ready));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Reads stay three cycles apart so each pop has landed before the next
  task automatic rd(input logic [7:0] a, input logic b16);
    logic [15:0] d;
    logic two;
    logic take;
    int i;
    int j;
    i = cpu_read_attach[1];
    j = cpu_write_attach[1];
    d = 16'h0000;
    two = 1'b0;
    take = (a == 8'h30 || a == 8'h31) && cpu_read_attach != 2'h0 && rc[i] != 13'h0;
    if (take) begin
      two = b16 && rc[i] > 13'h1;
      d = two ? {rp[i] + 8'h01, rp[i]} : {8'h00, rp[i]};
      rc[i] -= two ? 13'h2 : 13'h1;
      rp[i] += two ? 8'h02 : 8'h01;
    end else if (a == 8'h34) d = {8'h00, 3'h4, rc[i][12:8]};
    else if (a == 8'h35) d = {8'h00, rc[i][7:0]};
    else if (a == 8'h36) d = {8'h00, 3'h0, fc[j][12:8]};
    else if (a == 8'h37) d = {8'h00, fc[j][7:0]};
    // Pop expected from the take decision, so a zero data byte still counts
    rq.push_back({d, take ? cpu_read_attach : 2'h0, two});
    cpu_addr = a;
    cpu_bus16 = b16;
    cpu_rd = 1'b1;
    tick(1);
    cpu_rd = 1'b0;
    tick(2);
  endtask
  // Leaves the strobe high so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic b16, input logic drain);
    logic [15:0] d;
    logic two;
    int i;
    int n;
    d = 16'($urandom);
    i = cpu_write_attach[1];
    n = 0;
    while (drain && wr_push !== 2'h0 || cpu_wr_ready !== 1'b1) begin
      saw_full |= !drain;
      cpu_wr = 1'b0;
      tick(1);
      if (++n > 60) begin
        errors++;
        end_of_test();
      end
    end
    if (drain) begin
      cpu_wr = 1'b0; // The held strobe must not be sampled twice during the wait
      tick(1);
    end
    if ((a == 8'h32 || a == 8'h33) && cpu_write_attach != 2'h0 && fc[i] != 13'h0) begin
      two = b16 && fc[i] > 13'h1;
      wq.push_back({two ? d : {8'h00, d[7:0]}, cpu_write_attach, two});
      fc[i] -= two ? 13'h2 : 13'h1;
    end
    cpu_addr = a;
    cpu_wdata = d;
    cpu_bus16 = b16;
    cpu_wr = 1'b1;
    tick(1);
  endtask
  // Watcher: each answer is matched with the oldest note
  always @(posedge ref_clk) begin
    if (cpu_rdata_valid === 1'b1) begin
      if (rq.size() == 0) chk(19'h1, 19'h0);
      else chk({cpu_rdata, rd_pop, rd_pop_two}, rq.pop_front());
    end
    if ((|(wr_push & wr_dst_ready)) === 1'b1) begin
      if (wq.size() == 0) chk(19'h1, 19'h0);
      else chk({wr_push_two ? wr_push_data : {8'h00, wr_push_data[7:0]}, wr_push,
        wr_push_two}, wq.pop_front());
    end
  end
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(96133));
    tick(5);
    chk({cpu_rdata, wr_push, cpu_wr_ready}, 19'h0);
    rst_n = 1'b1;
    tick(1);
    cpu_read_attach = 2'h1;
    rd(8'h34, 1'b0);
    rd(8'h35, 1'b0);
    rd(8'h30, 1'b1);
    rd(8'h31, 1'b1);
    rd(8'h30, 1'b1);
    cpu_read_attach = 2'h2;
    rd(8'h31, 1'b0);
    rd(8'h30, 1'b0);
    rd(8'h34, 1'b0);
    rd(8'h35, 1'b0);
    for (int a = 8'h2A; a <= 8'h2F; a++) rd(8'(a), 1'b1);
    cpu_read_attach = 2'h0;
    rd(8'h30, 1'b1);
    cpu_write_attach = 2'h2;
    rd(8'h36, 1'b0);
    rd(8'h37, 1'b0);
    repeat (8) wr(8'h32, 1'b1, 1'b0);
    chk({18'h0, saw_full}, 19'h1);
    cpu_write_attach = 2'h1;
    wr(8'h33, 1'b1, 1'b1);
    wr(8'h32, 1'b1, 1'b1);
    wr(8'h32, 1'b1, 1'b1);
    cpu_write_attach = 2'h2;
    wr(8'h33, 1'b0, 1'b1);
    wr(8'h2A, 1'b1, 1'b1);
    cpu_write_attach = 2'h0;
    wr(8'h32, 1'b1, 1'b1);
    cpu_wr = 1'b0;
    tick(40);
    cpu_write_attach = 2'h2;
    rd(8'h36, 1'b0);
    rd(8'h37, 1'b0);
    chk(19'(rq.size() + wq.size()), 19'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
